// ==== pkg/pcif_pkg.sv ====
// Package for the pin change interrupt flag block: register map, field layouts, types
package pcif_pkg;

  // Register byte offsets (chosen, no offsets printed)
  localparam logic [7:0] PCIF_OFS_RISE = 8'h00;
  localparam logic [7:0] PCIF_OFS_FALL = 8'h04;
  localparam logic [7:0] PCIF_OFS_FLAGS = 8'h08;
  localparam logic [7:0] PCIF_OFS_ICTL = 8'h0C;
  localparam logic [7:0] PCIF_OFS_ISTAT = 8'h10;
  localparam logic [7:0] PCIF_OFS_IMASK = 8'h14;

  // Pin count and register width
  localparam int PCIF_PINS = 4;
  localparam int PCIF_REG_W = 8;

  // Interrupt control layout: master enable bit 3, summary flag bit 0
  localparam int PCIF_ICTL_MEN_BIT = 3;
  localparam int PCIF_ICTL_SUM_BIT = 0;

  // Sticky event status layout: change request, wake
  localparam int PCIF_EV_W = 2;
  localparam int PCIF_EV_REQ_BIT = 0;
  localparam int PCIF_EV_WAKE_BIT = 1;

  // Reset values
  localparam logic [3:0] PCIF_RST_PINS = 4'h0;
  localparam logic [1:0] PCIF_RST_EV = 2'h0;

  // AXI response codes
  localparam logic [1:0] PCIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCIF_RESP_SLVERR = 2'h2;

  // Bundled per-pin configuration
  typedef struct packed {
    logic [PCIF_PINS-1:0] rise_en;
    logic [PCIF_PINS-1:0] fall_en;
    logic master_en;
  } pcif_cfg_t;

endpackage : pcif_pkg

// ==== verilog/pcif_top.sv ====
// Pin change interrupt flag block with AXI4-Lite register slave
//
// Notes on behaviour
// - Enabled edge sets pin flag regardless master
// - Request only when flag set and master
// - Summary flag is OR of pin flags
// - Writing zero clears a flag; otherwise sticky
// - Edge during clearing write keeps flag set
// - Master enable lets pin change wake device
// - Sleep edge recorded before first instruction
// - Rising enables in bits 3 to 0
// - Falling enables in bits 3 to 0
// - Flag set on enabled rise or fall
// - Bits 7 to 4 ignore writes, read zero
// - Both enables detect both polarities
// - Master off: flags still set, no request
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module pcif_top
  import pcif_pkg::*;
#(
  parameter int NUM_PINS = PCIF_PINS
) (
  input wire logic core_clk,
  input wire logic srst,
  // Port pins, asynchronous to the core
  input wire logic [NUM_PINS-1:0] port_pin,
  // Sleep state of the core
  input wire logic asleep,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Change interrupt request level
  output logic change_irq,
  // Wake request to the sleep controller
  output logic wake_req,
  // Gated block interrupt line
  output logic irq
);

  // Logic is fixed at four enables per register
  initial begin
    if (NUM_PINS != PCIF_PINS) begin
      $error("pcif_top: NUM_PINS must equal 4");
    end
  end

  // Place an 8-bit field into a 32-bit read word, upper bits zero
  function automatic logic [31:0] pcif_word(input logic [PCIF_REG_W-1:0] v);
    pcif_word = {24'h000000, v};
  endfunction : pcif_word

  // Synchroniser and previous-sample stages
  logic [NUM_PINS-1:0] sync_a;
  logic [NUM_PINS-1:0] sync_b;
  logic [NUM_PINS-1:0] prev_pin;
  // Configuration and flags
  pcif_cfg_t cfg;
  pcif_cfg_t next_cfg;
  logic [NUM_PINS-1:0] pin_change_flags;
  logic [NUM_PINS-1:0] next_flags;
  logic [PCIF_EV_W-1:0] ev_stat;
  logic [PCIF_EV_W-1:0] next_ev_stat;
  logic [PCIF_EV_W-1:0] ev_mask;
  logic [PCIF_EV_W-1:0] next_ev_mask;
  // Edge detection
  logic [NUM_PINS-1:0] rise_det;
  logic [NUM_PINS-1:0] fall_det;
  logic [NUM_PINS-1:0] edge_hit;
  logic change_summary_flag;
  logic change_irq_prev;
  logic wake_prev;
  // Bus state
  logic aw_held;
  logic next_aw_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic wr_fire;
  logic rd_fire;

  // Two-stage synchroniser plus one history stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_a <= PCIF_RST_PINS;
      sync_b <= PCIF_RST_PINS;
      prev_pin <= PCIF_RST_PINS;
    end else begin
      sync_a <= port_pin;
      sync_b <= sync_a;
      prev_pin <= sync_b;
    end
  end

  // Edge detect on synchronised samples; no clock gating so sleep edges still land
  always_comb begin
    rise_det = sync_b & ~prev_pin;
    fall_det = ~sync_b & prev_pin;
    edge_hit = (rise_det & cfg.rise_en) | (fall_det & cfg.fall_en);
  end

  // Summary is a pure OR, never stored
  assign change_summary_flag = |pin_change_flags;
  // Request gated by master enable only
  assign change_irq = change_summary_flag & cfg.master_en;
  // Wake while asleep on a pending change with master enabled
  assign wake_req = change_irq & asleep;

  // Bus handshakes: hold address and data until both present
  assign wr_fire = aw_held & w_held & ~bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready = ~w_held & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // Next state of configuration, flags and event status
  always_comb begin
    next_cfg = cfg;
    next_flags = pin_change_flags;
    next_ev_mask = ev_mask;
    next_ev_stat = ev_stat;
    // Register writes only when byte lane 0 is enabled
    if (wr_fire && w_strb[0]) begin
      case (aw_addr)
        PCIF_OFS_RISE: begin
          next_cfg.rise_en = w_data[NUM_PINS-1:0];
        end
        PCIF_OFS_FALL: begin
          next_cfg.fall_en = w_data[NUM_PINS-1:0];
        end
        PCIF_OFS_FLAGS: begin
          // Zeros clear, ones leave the flag alone
          next_flags = pin_change_flags & w_data[NUM_PINS-1:0];
        end
        PCIF_OFS_ICTL: begin
          next_cfg.master_en = w_data[PCIF_ICTL_MEN_BIT];
        end
        PCIF_OFS_ISTAT: begin
          next_ev_stat = ev_stat & ~w_data[PCIF_EV_W-1:0];
        end
        PCIF_OFS_IMASK: begin
          next_ev_mask = w_data[PCIF_EV_W-1:0];
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
    // Edges set last so they win over any clear in the same cycle
    next_flags = next_flags | edge_hit;
    if (change_irq && !change_irq_prev) begin
      next_ev_stat[PCIF_EV_REQ_BIT] = 1'b1;
    end
    if (wake_req && !wake_prev) begin
      next_ev_stat[PCIF_EV_WAKE_BIT] = 1'b1;
    end
  end

  // Register the configuration, flags and events
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg <= '0;
      pin_change_flags <= PCIF_RST_PINS;
      ev_stat <= PCIF_RST_EV;
      ev_mask <= PCIF_RST_EV;
      change_irq_prev <= 1'b0;
      wake_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pin_change_flags <= next_flags;
      ev_stat <= next_ev_stat;
      ev_mask <= next_ev_mask;
      change_irq_prev <= change_irq;
      wake_prev <= wake_req;
      irq <= |(next_ev_stat & next_ev_mask);
    end
  end

  // Next state of the bus slave
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // Write completes one cycle after both are held
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        PCIF_OFS_RISE, PCIF_OFS_FALL, PCIF_OFS_FLAGS,
        PCIF_OFS_ICTL, PCIF_OFS_ISTAT, PCIF_OFS_IMASK: begin
          next_bresp = PCIF_RESP_OKAY;
        end
        default: begin
          next_bresp = PCIF_RESP_SLVERR;
        end
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Reads answer the cycle after the address is taken
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = PCIF_RESP_OKAY;
      case (s_axi_araddr)
        PCIF_OFS_RISE: begin
          next_rdata = pcif_word({4'h0, cfg.rise_en});
        end
        PCIF_OFS_FALL: begin
          next_rdata = pcif_word({4'h0, cfg.fall_en});
        end
        PCIF_OFS_FLAGS: begin
          next_rdata = pcif_word({4'h0, pin_change_flags});
        end
        PCIF_OFS_ICTL: begin
          next_rdata = pcif_word({4'h0, cfg.master_en, 2'h0, change_summary_flag});
        end
        PCIF_OFS_ISTAT: begin
          next_rdata = pcif_word({6'h00, ev_stat});
        end
        PCIF_OFS_IMASK: begin
          next_rdata = pcif_word({6'h00, ev_mask});
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = PCIF_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register the bus slave state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= PCIF_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= PCIF_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule : pcif_top

`default_nettype wire

// ==== verif/pcif_props.sv ====
// Port-level checker for the pin change interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module pcif_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic asleep,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic change_irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Both write halves taken at one edge
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response two edges later, not sooner
  sequence s_wr_resp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_lat: assert property (s_wr_both |=> s_wr_resp)
    else $error("write response timing wrong");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted with data pending");
  // Sticky: request only drops as a write completes
  a_sticky_drop: assert property ($fell(change_irq) |-> $rose(s_axi_bvalid))
    else $error("change request dropped without a write");
  a_wake_gate: assert property (wake_req == (change_irq && asleep))
    else $error("wake request not tied to change request");
endmodule : pcif_props
bind pcif_top pcif_props i_props (.core_clk, .srst, .asleep, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .change_irq, .wake_req);
`default_nettype wire

// ==== verif/pcif_pin_model.sv ====
// Port pin driver standing in for the outside world
`timescale 1ns/10ps
`default_nettype none
module pcif_pin_model (
  input wire logic core_clk,
  input wire logic [3:0] pin_req,
  output var logic [3:0] port_pin = 4'h0
);
  // Pins move just after an edge, never on it
  always @(posedge core_clk) port_pin <= #1 pin_req;
endmodule : pcif_pin_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the pin change interrupt flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
  import pcif_pkg::*;
  logic core_clk, srst, asleep;
  logic [3:0] pin_req, port_pin, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, change_irq, wake_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  int failures = 0, cmp_count = 0, cyc = 0;
  pcif_pin_model i_pins (.core_clk, .pin_req, .port_pin);
  pcif_top i_dut (.core_clk, .srst, .port_pin, .asleep, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .change_irq, .wake_req, .irq);
  // Verdict and end of run
  task final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Bus write; each channel dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  // Bus read into rv and rr
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  // Read and compare data and response
  task chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK("rdata", e, rv)
    `CHK("rresp", PCIF_RESP_OKAY, rr)
  endtask : chk
  // Clear only the flags seen set, by masking
  task clr();
    rd(PCIF_OFS_FLAGS);
    wr(PCIF_OFS_FLAGS, rv ^ 32'hFF);
    @(posedge core_clk);
  endtask : clr
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the run's length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {srst, asleep, pin_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    srst = 1'h1;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge core_clk);
    srst <= 1'h0;
    chk(PCIF_OFS_RISE, 32'h0);
    chk(PCIF_OFS_FALL, 32'h0);
    chk(PCIF_OFS_FLAGS, 32'h0);
    wr(PCIF_OFS_RISE, 32'hFF);
    wr(PCIF_OFS_FALL, 32'hF5);
    chk(PCIF_OFS_RISE, 32'h0F);
    chk(PCIF_OFS_FALL, 32'h05);
    // Lane 0 off: write answered but ignored
    s_axi_wstrb <= 4'hE;
    wr(PCIF_OFS_RISE, 32'h00);
    s_axi_wstrb <= 4'hF;
    `CHK("bresp", PCIF_RESP_OKAY, br)
    chk(PCIF_OFS_RISE, 32'h0F);
    // All pins rise with master off
    pin_req <= 4'hF;
    repeat (6) @(posedge core_clk);
    chk(PCIF_OFS_FLAGS, 32'h0F);
    `CHK("change_irq", 1'h0, change_irq)
    chk(PCIF_OFS_ICTL, 32'h01);
    clr();
    // Falls count only where enabled
    pin_req <= 4'h0;
    repeat (6) @(posedge core_clk);
    chk(PCIF_OFS_FLAGS, 32'h05);
    asleep <= 1'h1;
    wr(PCIF_OFS_ICTL, 32'h08);
    `CHK("change_irq", 1'h1, change_irq)
    `CHK("wake_req", 1'h1, wake_req)
    chk(PCIF_OFS_ISTAT, 32'h03);
    `CHK("irq", 1'h0, irq)
    wr(PCIF_OFS_IMASK, 32'h01);
    @(posedge core_clk);
    `CHK("irq", 1'h1, irq)
    wr(PCIF_OFS_ISTAT, 32'h03);
    @(posedge core_clk);
    `CHK("irq", 1'h0, irq)
    // Rises while asleep are recorded
    pin_req <= 4'hF;
    repeat (6) @(posedge core_clk);
    chk(PCIF_OFS_FLAGS, 32'h0F);
    // Falls land in the same cycle as a clear-all write
    pin_req <= 4'h0;
    @(posedge core_clk);
    wr(PCIF_OFS_FLAGS, 32'h00);
    chk(PCIF_OFS_FLAGS, 32'h05);
    clr();
    `CHK("change_irq", 1'h0, change_irq)
    chk(PCIF_OFS_ICTL, 32'h08);
    // Unmapped place answers with an error
    rd(8'h40);
    `CHK("rresp", PCIF_RESP_SLVERR, rr)
    `CHK("rdata", 32'h0, rv)
    wr(8'h40, 32'h0);
    `CHK("bresp", PCIF_RESP_SLVERR, br)
    final_report();
  end
endmodule : testbench
`default_nettype wire
